/* File: pkg/delay_measure_pkg.sv */
package delay_measure_pkg;

  // register byte offsets on the 32-bit bus
  localparam logic [7:0] TX_COARSE_OFFSET = 8'h4c;
  localparam logic [7:0] TX_FINE_OFFSET = 8'h50;
  localparam logic [7:0] RX_FINE_OFFSET = 8'h54;
  localparam logic [7:0] TX_HARD_OFFSET = 8'h84;
  localparam logic [7:0] RX_HARD_OFFSET = 8'h88;

  // widths of levels, period settings and sums
  localparam int unsigned LEVEL_W = 8;
  localparam int unsigned PERIOD_W = 8;
  localparam int unsigned ACC_W = 20;
  localparam int unsigned HARD_W = 15;
  localparam int unsigned CHANNELS = 6;

  // fine register layout: period, delay value, fresh flag
  localparam int unsigned PERIOD_LSB = 0;
  localparam int unsigned VALUE_LSB = 8;
  localparam int unsigned FRESH_BIT = 31;

  // hard fifo register layout: two counts, each with a fresh flag
  localparam int unsigned PCS_LSB = 0;
  localparam int unsigned PCS_FRESH_BIT = 15;
  localparam int unsigned CORE_LSB = 16;
  localparam int unsigned CORE_FRESH_BIT = 31;

  // sample count of one hard fifo window
  localparam logic [7:0] HARD_WINDOW = 8'h80;
  // period setting after reset; zero keeps the fine channels idle
  localparam logic [7:0] PERIOD_RESET = 8'h00;

  // channel slots of the measurement array
  localparam int unsigned CH_TX_FINE = 0;
  localparam int unsigned CH_RX_FINE = 1;
  localparam int unsigned CH_TX_PCS = 2;
  localparam int unsigned CH_TX_CORE = 3;
  localparam int unsigned CH_RX_PCS = 4;
  localparam int unsigned CH_RX_CORE = 5;

  // slots of the pin synchroniser
  localparam int unsigned PIN_FINE_CLK = 0;
  localparam int unsigned PIN_FINE_RST = 1;
  localparam int unsigned PIN_LAT_CLK = 2;
  localparam int unsigned PIN_LAT_RST = 3;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // requests from the bus master
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_type;

  // answers to the bus master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_type;

  // one averaging window
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [PERIOD_W-1:0] samples;
    logic [ACC_W-1:0] result;
    logic done;
  } window_state_type;

  localparam window_state_type WINDOW_RESET = '0;

  // top-level state
  typedef struct packed {
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [1:0] clk_prev;
    logic [PERIOD_W-1:0] tx_period;
    logic [PERIOD_W-1:0] rx_period;
    logic [CHANNELS-1:0] fresh;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } main_state_type;

  localparam main_state_type MAIN_RESET = '{
    pin_meta: 4'h0, pin_sync: 4'h0, clk_prev: 2'h0,
    tx_period: PERIOD_RESET, rx_period: PERIOD_RESET,
    fresh: 6'h00, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000};

endpackage : delay_measure_pkg

/* File: rtl/delay_window.sv */
`timescale 1ns/1ps
// sums a level over a window of sample strobes and posts the sum
module delay_window (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic strobe,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] level,
  input wire logic [delay_measure_pkg::PERIOD_W-1:0] period,
  output logic [delay_measure_pkg::ACC_W-1:0] result,
  output logic done
);

  // registered state and its next value
  delay_measure_pkg::window_state_type state;
  delay_measure_pkg::window_state_type next_state;

  // window arithmetic
  always_comb begin
    logic [delay_measure_pkg::ACC_W-1:0] sum;
    logic [delay_measure_pkg::PERIOD_W:0] count;
    sum = state.acc + delay_measure_pkg::ACC_W'(level);
    count = {1'b0, state.samples} + 9'h001;
    next_state = state;
    next_state.done = 1'b0;
    if (clear || period == '0) begin
      next_state.acc = '0;
      next_state.samples = '0;
    end else if (strobe) begin
      // sum of levels, one per period
      if (count >= {1'b0, period}) begin
        next_state.result = sum;
        next_state.acc = '0;
        next_state.samples = '0;
        next_state.done = 1'b1;
      end else begin
        next_state.acc = sum;
        next_state.samples = count[delay_measure_pkg::PERIOD_W-1:0];
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= delay_measure_pkg::WINDOW_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign result = state.result;
  assign done = state.done;

  // window closes with the full sum
  property p_window_close;
    @(posedge aclk) disable iff (!aresetn)
    (strobe && !clear && period != '0
      && ({1'b0, state.samples} + 9'h001) >= {1'b0, period})
    |=> (done && result == $past(state.acc
      + delay_measure_pkg::ACC_W'(level)));
  endproperty
  a_window_close: assert property (p_window_close)
    else $error("window sum not posted");

  // a clear empties the window at once
  property p_clear_empty;
    @(posedge aclk) disable iff (!aresetn)
    clear |=> (state.acc == '0 && state.samples == '0 && !done);
  endproperty
  a_clear_empty: assert property (p_clear_empty)
    else $error("clear left window state");

endmodule : delay_window

/* File: rtl/buffer_delay_measurement.sv */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module buffer_delay_measurement (
  input wire logic aclk,
  input wire logic aresetn,
  input wire delay_measure_pkg::axi_req_type axi_req,
  output delay_measure_pkg::axi_rsp_type axi_rsp,
  input wire logic fine_measure_clock,
  input wire logic fine_measure_reset_n,
  input wire logic latency_sample_clock,
  input wire logic latency_sample_reset_n,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] tx_buffer_words,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] rx_buffer_words,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] tx_pcs_fifo_level,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] tx_core_fifo_level,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] rx_pcs_fifo_level,
  input wire logic [delay_measure_pkg::LEVEL_W-1:0] rx_core_fifo_level,
  output logic [delay_measure_pkg::ACC_W-1:0] tx_fine_delay_value,
  output logic [delay_measure_pkg::ACC_W-1:0] rx_fine_delay_value,
  output logic tx_fine_delay_fresh,
  output logic rx_fine_delay_fresh
);

  localparam int unsigned CH = delay_measure_pkg::CHANNELS;

  // registered state and its next value
  delay_measure_pkg::main_state_type state;
  delay_measure_pkg::main_state_type next_state;

  // per-channel wiring of the window array
  logic [delay_measure_pkg::LEVEL_W-1:0] ch_level [CH];
  logic [delay_measure_pkg::PERIOD_W-1:0] ch_period [CH];
  logic [delay_measure_pkg::ACC_W-1:0] ch_result [CH];
  logic [CH-1:0] ch_clear;
  logic [CH-1:0] ch_strobe;
  logic [CH-1:0] ch_done;

  // edges and resets seen through the synchroniser
  logic fine_edge;
  logic lat_edge;
  logic fine_clear;
  logic lat_clear;

  // bus handshakes taken this cycle
  logic aw_take;
  logic ar_take;

  // rising edges of the synchronised clocks; the clocks must stay
  // below half the core rate or edges are lost
  // measurement clock edges
  assign fine_edge = state.pin_sync[delay_measure_pkg::PIN_FINE_CLK]
    & ~state.clk_prev[0];
  assign lat_edge = state.pin_sync[delay_measure_pkg::PIN_LAT_CLK]
    & ~state.clk_prev[1];
  assign fine_clear = ~state.pin_sync[delay_measure_pkg::PIN_FINE_RST];
  assign lat_clear = ~state.pin_sync[delay_measure_pkg::PIN_LAT_RST];

  // write takes address and data together, one response at a time
  assign aw_take = aresetn & axi_req.awvalid & axi_req.wvalid
    & ~state.bvalid;
  assign ar_take = aresetn & axi_req.arvalid & ~state.rvalid;

  // channel inputs: fine pair, then hard fifo pairs
  assign ch_level[delay_measure_pkg::CH_TX_FINE] = tx_buffer_words;
  assign ch_level[delay_measure_pkg::CH_RX_FINE] = rx_buffer_words;
  assign ch_level[delay_measure_pkg::CH_TX_PCS] = tx_pcs_fifo_level;
  assign ch_level[delay_measure_pkg::CH_TX_CORE] = tx_core_fifo_level;
  assign ch_level[delay_measure_pkg::CH_RX_PCS] = rx_pcs_fifo_level;
  assign ch_level[delay_measure_pkg::CH_RX_CORE] = rx_core_fifo_level;
  assign ch_period[delay_measure_pkg::CH_TX_FINE] = state.tx_period;
  assign ch_period[delay_measure_pkg::CH_RX_FINE] = state.rx_period;
  assign ch_period[delay_measure_pkg::CH_TX_PCS] =
    delay_measure_pkg::HARD_WINDOW;
  assign ch_period[delay_measure_pkg::CH_TX_CORE] =
    delay_measure_pkg::HARD_WINDOW;
  assign ch_period[delay_measure_pkg::CH_RX_PCS] =
    delay_measure_pkg::HARD_WINDOW;
  assign ch_period[delay_measure_pkg::CH_RX_CORE] =
    delay_measure_pkg::HARD_WINDOW;

  generate
    for (genvar i = 0; i < CH; i++) begin : g_channel
      // fine channels on the measurement clock, the rest on latency
      if (i < 2) begin : g_fine
        assign ch_clear[i] = fine_clear;
        assign ch_strobe[i] = fine_edge;
      end else begin : g_hard
        assign ch_clear[i] = lat_clear;
        assign ch_strobe[i] = lat_edge;
      end
      delay_window u_window (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(ch_clear[i]),
        .strobe(ch_strobe[i]),
        .level(ch_level[i]),
        .period(ch_period[i]),
        .result(ch_result[i]),
        .done(ch_done[i])
      );
    end
  endgenerate

  // next state: synchroniser, register writes, reads, fresh flags
  always_comb begin
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [CH-1:0] read_clear;
    rd = 32'h0000_0000;
    rresp = delay_measure_pkg::RESP_OKAY;
    read_clear = '0;
    next_state = state;
    // two flops per pin before any logic looks
    next_state.pin_meta = {latency_sample_reset_n, latency_sample_clock,
      fine_measure_reset_n, fine_measure_clock};
    next_state.pin_sync = state.pin_meta;
    next_state.clk_prev = {state.pin_sync[delay_measure_pkg::PIN_LAT_CLK],
      state.pin_sync[delay_measure_pkg::PIN_FINE_CLK]};

    // write channel
    if (aw_take) begin
      next_state.bvalid = 1'b1;
      next_state.bresp = delay_measure_pkg::RESP_OKAY;
      unique case (axi_req.awaddr)
        delay_measure_pkg::TX_FINE_OFFSET: begin
          if (axi_req.wstrb[0]) begin
            next_state.tx_period = axi_req.wdata[7:0];
          end
        end
        delay_measure_pkg::RX_FINE_OFFSET: begin
          if (axi_req.wstrb[0]) begin
            next_state.rx_period = axi_req.wdata[7:0];
          end
        end
        // read-only registers ignore the write
        delay_measure_pkg::TX_COARSE_OFFSET,
        delay_measure_pkg::TX_HARD_OFFSET,
        delay_measure_pkg::RX_HARD_OFFSET: begin
          next_state.bresp = delay_measure_pkg::RESP_OKAY;
        end
        // unmapped
        default: begin
          next_state.bresp = delay_measure_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state.bvalid && axi_req.bready) begin
      next_state.bvalid = 1'b0;
    end

    // read mux
    unique case (axi_req.araddr)
      delay_measure_pkg::TX_COARSE_OFFSET: begin
        rd[delay_measure_pkg::LEVEL_W-1:0] = tx_buffer_words;
      end
      delay_measure_pkg::TX_FINE_OFFSET: begin
        rd[7:0] = state.tx_period;
        rd[27:8] = ch_result[delay_measure_pkg::CH_TX_FINE];
        rd[delay_measure_pkg::FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_TX_FINE];
        read_clear[delay_measure_pkg::CH_TX_FINE] = 1'b1;
      end
      delay_measure_pkg::RX_FINE_OFFSET: begin
        rd[7:0] = state.rx_period;
        rd[27:8] = ch_result[delay_measure_pkg::CH_RX_FINE];
        rd[delay_measure_pkg::FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_RX_FINE];
        read_clear[delay_measure_pkg::CH_RX_FINE] = 1'b1;
      end
      delay_measure_pkg::TX_HARD_OFFSET: begin
        rd[14:0] = ch_result[delay_measure_pkg::CH_TX_PCS][14:0];
        rd[delay_measure_pkg::PCS_FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_TX_PCS];
        rd[30:16] = ch_result[delay_measure_pkg::CH_TX_CORE][14:0];
        rd[delay_measure_pkg::CORE_FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_TX_CORE];
        read_clear[delay_measure_pkg::CH_TX_PCS] = 1'b1;
        read_clear[delay_measure_pkg::CH_TX_CORE] = 1'b1;
      end
      delay_measure_pkg::RX_HARD_OFFSET: begin
        rd[14:0] = ch_result[delay_measure_pkg::CH_RX_PCS][14:0];
        rd[delay_measure_pkg::PCS_FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_RX_PCS];
        rd[30:16] = ch_result[delay_measure_pkg::CH_RX_CORE][14:0];
        rd[delay_measure_pkg::CORE_FRESH_BIT] =
          state.fresh[delay_measure_pkg::CH_RX_CORE];
        read_clear[delay_measure_pkg::CH_RX_PCS] = 1'b1;
        read_clear[delay_measure_pkg::CH_RX_CORE] = 1'b1;
      end
      // unmapped reads zero with an error
      default: begin
        rresp = delay_measure_pkg::RESP_SLVERR;
      end
    endcase

    // read channel; data held until the master takes it
    if (ar_take) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = rd;
      next_state.rresp = rresp;
    end else if (state.rvalid && axi_req.rready) begin
      next_state.rvalid = 1'b0;
      read_clear = '0;
    end else begin
      read_clear = '0;
    end

    next_state.fresh = state.fresh & ~read_clear
      & ~{{4{lat_clear}}, {2{fine_clear}}};
    // new value sets, set beats clear
    next_state.fresh = next_state.fresh | ch_done;
  end

  // state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= delay_measure_pkg::MAIN_RESET;
    end else begin
      state <= next_state;
    end
  end

  // bus answers from state, but awready and wready follow the write take and arready also needs aresetn
  always_comb begin
    axi_rsp.awready = aw_take;
    axi_rsp.wready = aw_take;
    axi_rsp.bvalid = state.bvalid;
    axi_rsp.bresp = state.bresp;
    axi_rsp.arready = aresetn & ~state.rvalid;
    axi_rsp.rvalid = state.rvalid;
    axi_rsp.rdata = state.rdata;
    axi_rsp.rresp = state.rresp;
  end

  // side outputs of the fine measurement
  assign tx_fine_delay_value = ch_result[delay_measure_pkg::CH_TX_FINE];
  assign rx_fine_delay_value = ch_result[delay_measure_pkg::CH_RX_FINE];
  assign tx_fine_delay_fresh = state.fresh[delay_measure_pkg::CH_TX_FINE];
  assign rx_fine_delay_fresh = state.fresh[delay_measure_pkg::CH_RX_FINE];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // read of a register, named by offset
  sequence s_read(logic [7:0] addr);
    ar_take && axi_req.araddr == addr;
  endsequence

  // a new value always raises the flag
  property p_fresh_set;
    ch_done[delay_measure_pkg::CH_RX_FINE] |=> rx_fine_delay_fresh;
  endproperty
  a_fresh_set: assert property (p_fresh_set)
    else $error("rx fresh flag missed a new value");

  // a read with no new value leaves the flag low
  property p_read_clears;
    s_read(delay_measure_pkg::RX_FINE_OFFSET)
      && !ch_done[delay_measure_pkg::CH_RX_FINE]
    |=> !rx_fine_delay_fresh;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("rx fresh flag survived a read");

  // coarse read returns the word count seen at the take
  property p_coarse_read;
    s_read(delay_measure_pkg::TX_COARSE_OFFSET)
    |=> axi_rsp.rvalid && axi_rsp.rdata[7:0] == $past(tx_buffer_words);
  endproperty
  a_coarse_read: assert property (p_coarse_read)
    else $error("coarse read returned wrong count");

  // a period write lands in the tx setting
  property p_period_write;
    aw_take && axi_req.awaddr == delay_measure_pkg::TX_FINE_OFFSET
      && axi_req.wstrb[0]
    |=> state.tx_period == $past(axi_req.wdata[7:0]);
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("tx period not stored");

  // a measurement strobe only follows a low synchronised clock
  property p_edge_spacing;
    fine_edge
    |-> !$past(state.pin_sync[delay_measure_pkg::PIN_FINE_CLK]);
  endproperty
  a_edge_spacing: assert property (p_edge_spacing)
    else $error("measurement edges too close");

  // hard register read shows both flags as they stood
  property p_hard_flags;
    s_read(delay_measure_pkg::TX_HARD_OFFSET)
    |=> axi_rsp.rdata[delay_measure_pkg::PCS_FRESH_BIT]
        == $past(state.fresh[delay_measure_pkg::CH_TX_PCS])
      && axi_rsp.rdata[delay_measure_pkg::CORE_FRESH_BIT]
        == $past(state.fresh[delay_measure_pkg::CH_TX_CORE]);
  endproperty
  a_hard_flags: assert property (p_hard_flags)
    else $error("tx hard flags misreported");

  // held latency reset keeps the hard flags down; three cycles, since
  // a window posted just before the reset still sets its flag
  property p_lat_reset;
    lat_clear [*3] |-> state.fresh[5:2] == 4'h0;
  endproperty
  a_lat_reset: assert property (p_lat_reset)
    else $error("hard flags set under latency reset");

  // the read answer holds until taken
  property p_read_hold;
    axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read answer dropped before taken");

endmodule : buffer_delay_measurement

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // core clock and bus signals
  logic aclk = 1'b0;
  logic aresetn;
  delay_measure_pkg::axi_req_type req;
  delay_measure_pkg::axi_rsp_type rsp;
  // measurement pins, made here as slow data-like clocks
  logic fclk = 1'b0;
  logic lclk = 1'b0;
  logic frst_n, lrst_n;
  logic fine_run, lat_run;
  logic [1:0] fcnt = 2'h0;
  logic [1:0] lcnt = 2'h0;
  // occupancy levels fed to the block
  logic [7:0] tx_words, rx_words, tx_pcs, tx_core, rx_pcs, rx_core;
  logic [19:0] tx_val, rx_val;
  logic tx_fr, rx_fr;
  logic [31:0] rd;
  logic [1:0] rs;
  int fails = 0;
  int n_compared = 0;
  // one register access: write, then read back
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [1:0] wresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } row_type;
  row_type rows [6];

  buffer_delay_measurement uut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .fine_measure_clock(fclk), .fine_measure_reset_n(frst_n),
    .latency_sample_clock(lclk), .latency_sample_reset_n(lrst_n),
    .tx_buffer_words(tx_words), .rx_buffer_words(rx_words),
    .tx_pcs_fifo_level(tx_pcs), .tx_core_fifo_level(tx_core),
    .rx_pcs_fifo_level(rx_pcs), .rx_core_fifo_level(rx_core),
    .tx_fine_delay_value(tx_val), .rx_fine_delay_value(rx_val),
    .tx_fine_delay_fresh(tx_fr), .rx_fine_delay_fresh(rx_fr));

  // core clock, 4 ns
  always #2 aclk = ~aclk;

  // measurement clocks at a quarter rate, still (low) when stopped
  // measurement clock derived from the core clock
  // latency clock at the measurement clock rate
  always @(posedge aclk) begin
    fcnt <= fine_run ? fcnt + 2'h1 : 2'h0;
    fclk <= fine_run & fcnt[1];
    lcnt <= lat_run ? lcnt + 2'h1 : 2'h0;
    lclk <= lat_run & lcnt[1];
  end

  // verdict and end of run
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  // data comparison, unknowns never match
  task automatic check_word(input string name, input logic [31:0] exp,
                            input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  // bus response comparison
  task automatic check_resp(input string name, input logic [1:0] exp,
                            input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_resp

  // a wait that ran out ends the run
  task automatic timeout(input string name);
    fails++;
    $display("MISMATCH %s expected answer seen none", name);
    results();
  endtask : timeout

  // write: address and data offered together, sampled before each edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    int i;
    @(posedge aclk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    i = 0;
    do begin @(negedge aclk); i++; end
    while (!(rsp.awready === 1'b1 && rsp.wready === 1'b1) && i < 100);
    if (i >= 100) timeout("awready");
    @(posedge aclk);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    i = 0;
    do begin @(negedge aclk); i++; end
    while (rsp.bvalid !== 1'b1 && i < 100);
    if (i >= 100) timeout("bvalid");
    resp = rsp.bresp;
    @(posedge aclk);
    req.bready <= 1'b0;
  endtask : bus_write

  // read: data and response taken at the edge that sees rvalid
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int i;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    i = 0;
    do begin @(negedge aclk); i++; end
    while (rsp.arready !== 1'b1 && i < 100);
    if (i >= 100) timeout("arready");
    @(posedge aclk);
    req.arvalid <= 1'b0;
    i = 0;
    do begin @(negedge aclk); i++; end
    while (rsp.rvalid !== 1'b1 && i < 100);
    if (i >= 100) timeout("rvalid");
    d = rsp.rdata;
    resp = rsp.rresp;
    @(posedge aclk);
    req.rready <= 1'b0;
  endtask : bus_read

  // one fine measurement run per direction with constant levels
  task automatic fine_case(input logic [7:0] tn, tl, rn, rl);
    logic [19:0] tv, rv;
    int i;
    tv = tn * tl;
    rv = rn * rl;
    @(posedge aclk);
    frst_n <= 1'b0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    check_word("tx_fresh", 32'h0, {31'h0, tx_fr});
    @(posedge aclk);
    frst_n <= 1'b1;
    tx_words <= tl;
    rx_words <= rl;
    bus_write(delay_measure_pkg::TX_FINE_OFFSET, {24'h0, tn}, rs);
    bus_write(delay_measure_pkg::RX_FINE_OFFSET, {24'h0, rn}, rs);
    fine_run <= 1'b1;
    // values are only used once flagged fresh
    i = 0;
    do begin @(negedge aclk); i++; end
    while (!(tx_fr === 1'b1 && rx_fr === 1'b1) && i < 3000);
    if (i >= 3000) timeout("fine fresh");
    @(posedge aclk);
    fine_run <= 1'b0;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    // value is sum of N samples, same logic both ways
    check_word("tx_value", {12'h0, tv}, {12'h0, tx_val});
    check_word("rx_value", {12'h0, rv}, {12'h0, rx_val});
    bus_read(delay_measure_pkg::TX_FINE_OFFSET, rd, rs);
    check_word("tx_fine", {4'h8, tv, tn}, rd);
    @(negedge aclk);
    check_word("tx_fresh", 32'h0, {31'h0, tx_fr});
    check_word("rx_fresh", 32'h1, {31'h0, rx_fr});
    bus_read(delay_measure_pkg::RX_FINE_OFFSET, rd, rs);
    check_word("rx_fine", {4'h8, rv, rn}, rd);
    bus_read(delay_measure_pkg::TX_FINE_OFFSET, rd, rs);
    check_word("tx_fine", {4'h0, tv, tn}, rd);
  endtask : fine_case

  // main sequence
  initial begin
    int i;
    req = '0;
    aresetn = 1'b0;
    {frst_n, lrst_n, fine_run, lat_run} = 4'h0;
    tx_words = 8'h21;
    {rx_words, tx_pcs, tx_core, rx_pcs, rx_core} = 40'h0;
    rows[0] = '{8'h4c, 32'h0000_0055, 2'h0, 32'h0000_0021, 2'h0};
    rows[1] = '{8'h50, 32'hffff_ff05, 2'h0, 32'h0000_0005, 2'h0};
    rows[2] = '{8'h54, 32'h0000_0102, 2'h0, 32'h0000_0002, 2'h0};
    rows[3] = '{8'h84, 32'hffff_ffff, 2'h0, 32'h0000_0000, 2'h0};
    rows[4] = '{8'h88, 32'hffff_ffff, 2'h0, 32'h0000_0000, 2'h0};
    rows[5] = '{8'h40, 32'h1234_5678, 2'h2, 32'h0000_0000, 2'h2};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // register table: read-only places ignore writes
    foreach (rows[k]) begin
      bus_write(rows[k].addr, rows[k].wdata, rs);
      check_resp("wresp", rows[k].wresp, rs);
      bus_read(rows[k].addr, rd, rs);
      check_resp("rresp", rows[k].rresp, rs);
      check_word("rdata", rows[k].rdata, rd);
    end
    fine_case(8'h03, 8'h05, 8'h02, 8'h07);
    fine_case(8'h01, 8'hff, 8'hff, 8'hff);
    // hard fifo windows of 128 samples
    {tx_pcs, tx_core, rx_pcs, rx_core} <= 32'h0102_0304;
    lrst_n <= 1'b1;
    lat_run <= 1'b1;
    i = 0;
    do begin
      bus_read(delay_measure_pkg::TX_HARD_OFFSET, rd, rs);
      i++;
    end while (rd[31] !== 1'b1 && i < 300);
    if (i >= 300) timeout("hard fresh");
    check_word("tx_hard", 32'h8100_8080, rd);
    @(posedge aclk);
    lat_run <= 1'b0;
    repeat (8) @(posedge aclk);
    bus_read(delay_measure_pkg::RX_HARD_OFFSET, rd, rs);
    check_word("rx_hard", 32'h8200_8180, rd);
    bus_read(delay_measure_pkg::TX_HARD_OFFSET, rd, rs);
    check_word("tx_hard", 32'h0100_0080, rd);
    // held latency reset blocks new windows past one full window
    @(posedge aclk);
    lrst_n <= 1'b0;
    lat_run <= 1'b1;
    repeat (600) @(posedge aclk);
    bus_read(delay_measure_pkg::TX_HARD_OFFSET, rd, rs);
    check_word("hard_flags", 32'h0, rd & 32'h8000_8000);
    lat_run <= 1'b0;
    // core reset mid-run clears outputs and periods
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check_word("tx_value", 32'h0, {12'h0, tx_val});
    check_word("arready", 32'h0, {31'h0, rsp.arready});
    @(posedge aclk);
    aresetn <= 1'b1;
    bus_read(delay_measure_pkg::TX_FINE_OFFSET, rd, rs);
    check_word("tx_fine", 32'h0, rd);
    // period zero keeps the channel idle
    fine_run <= 1'b1;
    repeat (40) @(posedge aclk);
    @(negedge aclk);
    check_word("tx_fresh", 32'h0, {31'h0, tx_fr});
    results();
  end
endmodule : testbench
